//--- hw/squr_pkg.sv
// Operation
// - only the device writes the used ring
// - used element holds chain head and length
// - used index starts at zero, only increases
// - length and data written before index update
// - device may write more than reported length
// - in-order batch reported by last chain head
// - used index advances by the batch size
// - without event index flags are 0 or 1
// - with event index flags zero, threshold used
// - spurious notifications are tolerated
// - 16-bit wrapping indices, queue at most 32768
// - device may fetch right after index advance
// - descriptor flag encoding and 16-byte layout
package squr_pkg;
	localparam logic [7:0]  REG_CTRL      = 8'h00;
	localparam logic [7:0]  REG_QSIZE     = 8'h04;
	localparam logic [7:0]  REG_AVL_LO    = 8'h08;
	localparam logic [7:0]  REG_AVL_HI    = 8'h0c;
	localparam logic [7:0]  REG_USD_LO    = 8'h10;
	localparam logic [7:0]  REG_USD_HI    = 8'h14;
	localparam logic [7:0]  REG_KICK      = 8'h18;
	localparam logic [7:0]  REG_THR       = 8'h1c;
	localparam logic [7:0]  REG_STAT      = 8'h20;
	localparam int          CTRL_EN       = 0;
	localparam int          CTRL_INORD    = 1;
	localparam int          CTRL_EVIDX    = 2;
	localparam int          CTRL_SUPP     = 3;
	localparam logic [3:0]  CTRL_RST      = 4'h0;
	localparam logic [15:0] QSIZE_RST     = 16'h0100;
	localparam logic [15:0] QSIZE_MAX     = 16'h8000;
	localparam logic [15:0] IDX_RST       = 16'h0000;
	localparam logic [15:0] THR_RST       = 16'h0000;
	localparam logic [63:0] USED_FLG_OFF  = 64'h0;
	localparam logic [63:0] USED_IDX_OFF  = 64'h2;
	localparam logic [63:0] AVL_IDX_OFF   = 64'h2;
	localparam logic [63:0] RING_OFF      = 64'h4;
	localparam int          USED_ELEM_SH  = 3;
	localparam int          AVL_ENT_SH    = 1;
	localparam logic [15:0] FLG_NO_NOTIFY = 16'h0001;
	localparam logic [15:0] DESC_CHAIN    = 16'h0001;
	localparam logic [15:0] DESC_DEV_WR   = 16'h0002;
	localparam logic [15:0] DESC_INDIRECT = 16'h0004;
	localparam int          DESC_BYTES    = 16;
	localparam logic [1:0]  RESP_OKAY     = 2'b00;
	localparam logic [1:0]  RESP_SLVERR   = 2'b10;

	typedef struct packed {
		logic [63:0] addr;
		logic [31:0] wdata;
		logic [3:0]  strb;
		logic        we;
	} squr_mreq_t;

	typedef struct packed {
		logic [31:0] head;
		logic [31:0] wlen;
		logic [15:0] batch;
	} squr_cmpl_t;
endpackage

//--- hw/squr_axil.sv
`timescale 1ns/1ps
module squr_axil (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [7:0]  s_axil_awaddr,
	input  wire logic        s_axil_awvalid,
	output logic             s_axil_awready,
	input  wire logic [31:0] s_axil_wdata,
	input  wire logic [3:0]  s_axil_wstrb,
	input  wire logic        s_axil_wvalid,
	output logic             s_axil_wready,
	output logic [1:0]       s_axil_bresp,
	output logic             s_axil_bvalid,
	input  wire logic        s_axil_bready,
	input  wire logic [7:0]  s_axil_araddr,
	input  wire logic        s_axil_arvalid,
	output logic             s_axil_arready,
	output logic [31:0]      s_axil_rdata,
	output logic [1:0]       s_axil_rresp,
	output logic             s_axil_rvalid,
	input  wire logic        s_axil_rready,
	output logic             wr_en,
	output logic [7:0]       wr_addr,
	output logic [31:0]      wr_data,
	output logic [3:0]       wr_strb,
	input  wire logic        wr_err,
	output logic             rd_en,
	output logic [7:0]       rd_addr,
	input  wire logic [31:0] rd_data,
	input  wire logic        rd_err
);
	logic aw_held_r;
	logic w_held_r;

	assign s_axil_awready = !aw_held_r;
	assign s_axil_wready  = !w_held_r;
	// one write in flight: the next write is held until b is taken
	assign wr_en   = aw_held_r && w_held_r && !s_axil_bvalid;
	assign s_axil_arready = !s_axil_rvalid;
	assign rd_en   = s_axil_arvalid && s_axil_arready;
	assign rd_addr = s_axil_araddr;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_r <= 1'b0;
			wr_addr   <= 8'h00;
		end else if (s_axil_awvalid && s_axil_awready) begin
			aw_held_r <= 1'b1;
			wr_addr   <= s_axil_awaddr;
		end else if (wr_en) begin
			aw_held_r <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held_r <= 1'b0;
			wr_data  <= 32'h0;
			wr_strb  <= 4'h0;
		end else if (s_axil_wvalid && s_axil_wready) begin
			w_held_r <= 1'b1;
			wr_data  <= s_axil_wdata;
			wr_strb  <= s_axil_wstrb;
		end else if (wr_en) begin
			w_held_r <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axil_bvalid <= 1'b0;
			s_axil_bresp  <= squr_pkg::RESP_OKAY;
		end else if (wr_en) begin
			s_axil_bvalid <= 1'b1;
			s_axil_bresp  <= wr_err ? squr_pkg::RESP_SLVERR
				: squr_pkg::RESP_OKAY;
		end else if (s_axil_bready) begin
			s_axil_bvalid <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axil_rvalid <= 1'b0;
			s_axil_rdata  <= 32'h0;
			s_axil_rresp  <= squr_pkg::RESP_OKAY;
		end else if (rd_en) begin
			s_axil_rvalid <= 1'b1;
			s_axil_rdata  <= rd_data;
			s_axil_rresp  <= rd_err ? squr_pkg::RESP_SLVERR
				: squr_pkg::RESP_OKAY;
		end else if (s_axil_rready) begin
			s_axil_rvalid <= 1'b0;
		end
	end
endmodule

//--- hw/squr_used_ring.sv
// Chosen here: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
module squr_used_ring (
	input  wire logic                 aclk,
	input  wire logic                 aresetn,
	input  wire logic [7:0]           s_axil_awaddr,
	input  wire logic                 s_axil_awvalid,
	output logic                      s_axil_awready,
	input  wire logic [31:0]          s_axil_wdata,
	input  wire logic [3:0]           s_axil_wstrb,
	input  wire logic                 s_axil_wvalid,
	output logic                      s_axil_wready,
	output logic [1:0]                s_axil_bresp,
	output logic                      s_axil_bvalid,
	input  wire logic                 s_axil_bready,
	input  wire logic [7:0]           s_axil_araddr,
	input  wire logic                 s_axil_arvalid,
	output logic                      s_axil_arready,
	output logic [31:0]               s_axil_rdata,
	output logic [1:0]                s_axil_rresp,
	output logic                      s_axil_rvalid,
	input  wire logic                 s_axil_rready,
	output squr_pkg::squr_mreq_t      mem_req,
	output logic                      mem_req_valid,
	input  wire logic                 mem_req_ready,
	input  wire logic                 mem_rsp_valid,
	input  wire logic [31:0]          mem_rsp_rdata,
	input  wire squr_pkg::squr_cmpl_t cmpl_i,
	input  wire logic                 cmpl_valid,
	output logic                      cmpl_ready,
	output logic [15:0]               avail_head,
	output logic                      avail_valid,
	input  wire logic                 avail_ready
);
	typedef enum logic [1:0] {S_IDLE, S_REQ, S_RSP, S_OUT} squr_st_t;
	typedef enum logic [2:0] {
		P_FLG, P_THR, P_AIDX, P_AENT, P_EID, P_ELEN, P_UIDX
	} squr_ph_t;

	squr_st_t             state_r;
	squr_ph_t             phase_r;
	squr_pkg::squr_mreq_t mem_req_r;
	squr_pkg::squr_cmpl_t cmpl_r;
	logic [3:0]           ctrl_r;
	logic [15:0]          qsize_r;
	logic [63:0]          avl_base_r;
	logic [63:0]          usd_base_r;
	logic [15:0]          thr_r;
	logic [15:0]          last_avail_r;
	logic [15:0]          used_idx_r;
	logic [15:0]          avail_head_r;
	logic                 kick_pend_r;
	logic                 flags_dirty_r;
	logic                 len_done_r;
	logic                 wr_en;
	logic [7:0]           wr_addr;
	logic [31:0]          wr_data;
	logic [3:0]           wr_strb;
	logic                 rd_en;
	logic [7:0]           rd_addr;
	logic [31:0]          rd_data;
	logic                 kick_evt;
	logic                 flag_issue;
	logic [15:0]          step;
	logic [15:0]          flag_val;
	logic [15:0]          rsp_half;
	logic [63:0]          used_slot_addr;
	logic [63:0]          avl_slot_addr;
	logic [63:0]          kick_thr_addr;

	function automatic logic [15:0] ring_slot(input logic [15:0] idx,
		input logic [15:0] qs);
		ring_slot = idx & (qs - 16'h1);
	endfunction

	function automatic logic reg_ok(input logic [7:0] a);
		reg_ok = a == squr_pkg::REG_CTRL || a == squr_pkg::REG_QSIZE
			|| a == squr_pkg::REG_AVL_LO || a == squr_pkg::REG_AVL_HI
			|| a == squr_pkg::REG_USD_LO || a == squr_pkg::REG_USD_HI
			|| a == squr_pkg::REG_KICK || a == squr_pkg::REG_THR
			|| a == squr_pkg::REG_STAT;
	endfunction

	function automatic logic [31:0] mrg(input logic [31:0] o,
		input logic [31:0] n, input logic [3:0] s);
		for (int i = 0; i < 4; i++) begin
			mrg[8*i +: 8] = s[i] ? n[8*i +: 8] : o[8*i +: 8];
		end
	endfunction

	// 16-bit fields ride the lane pair picked by address bit 1
	function automatic squr_pkg::squr_mreq_t wr16(input logic [63:0] a,
		input logic [15:0] v);
		wr16.addr  = a;
		wr16.wdata = {v, v};
		wr16.strb  = a[1] ? 4'hc : 4'h3;
		wr16.we    = 1'b1;
	endfunction

	function automatic squr_pkg::squr_mreq_t wr32(input logic [63:0] a,
		input logic [31:0] v);
		wr32.addr  = a;
		wr32.wdata = v;
		wr32.strb  = 4'hf;
		wr32.we    = 1'b1;
	endfunction

	function automatic squr_pkg::squr_mreq_t rd16(input logic [63:0] a);
		rd16.addr  = a;
		rd16.wdata = 32'h0;
		rd16.strb  = 4'h0;
		rd16.we    = 1'b0;
	endfunction

	squr_axil u_axil (
		.aclk           (aclk),
		.aresetn        (aresetn),
		.s_axil_awaddr  (s_axil_awaddr),
		.s_axil_awvalid (s_axil_awvalid),
		.s_axil_awready (s_axil_awready),
		.s_axil_wdata   (s_axil_wdata),
		.s_axil_wstrb   (s_axil_wstrb),
		.s_axil_wvalid  (s_axil_wvalid),
		.s_axil_wready  (s_axil_wready),
		.s_axil_bresp   (s_axil_bresp),
		.s_axil_bvalid  (s_axil_bvalid),
		.s_axil_bready  (s_axil_bready),
		.s_axil_araddr  (s_axil_araddr),
		.s_axil_arvalid (s_axil_arvalid),
		.s_axil_arready (s_axil_arready),
		.s_axil_rdata   (s_axil_rdata),
		.s_axil_rresp   (s_axil_rresp),
		.s_axil_rvalid  (s_axil_rvalid),
		.s_axil_rready  (s_axil_rready),
		.wr_en          (wr_en),
		.wr_addr        (wr_addr),
		.wr_data        (wr_data),
		.wr_strb        (wr_strb),
		.wr_err         (!reg_ok(wr_addr)),
		.rd_en          (rd_en),
		.rd_addr        (rd_addr),
		.rd_data        (rd_data),
		.rd_err         (!reg_ok(rd_addr))
	);

	always_comb begin
		case (rd_addr)
		squr_pkg::REG_CTRL:   rd_data = {28'h0, ctrl_r};
		squr_pkg::REG_QSIZE:  rd_data = {16'h0, qsize_r};
		squr_pkg::REG_AVL_LO: rd_data = avl_base_r[31:0];
		squr_pkg::REG_AVL_HI: rd_data = avl_base_r[63:32];
		squr_pkg::REG_USD_LO: rd_data = usd_base_r[31:0];
		squr_pkg::REG_USD_HI: rd_data = usd_base_r[63:32];
		squr_pkg::REG_THR:    rd_data = {16'h0, thr_r};
		squr_pkg::REG_STAT:   rd_data = {used_idx_r, last_avail_r};
		default:              rd_data = 32'h0;
		endcase
	end

	// bases and size are not guarded: change them only while disabled
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_r     <= squr_pkg::CTRL_RST;
			qsize_r    <= squr_pkg::QSIZE_RST;
			avl_base_r <= 64'h0;
			usd_base_r <= 64'h0;
			thr_r      <= squr_pkg::THR_RST;
		end else if (wr_en) begin
			case (wr_addr)
			squr_pkg::REG_CTRL: ctrl_r <= wr_data[3:0];
			squr_pkg::REG_QSIZE: begin
				// whole word compared so 0x10000 is not taken as 0
				if (wr_data <= 32'(squr_pkg::QSIZE_MAX)) begin
					qsize_r <= wr_data[15:0];
				end
			end
			squr_pkg::REG_AVL_LO:
				avl_base_r[31:0] <= mrg(avl_base_r[31:0], wr_data, wr_strb);
			squr_pkg::REG_AVL_HI:
				avl_base_r[63:32] <= mrg(avl_base_r[63:32], wr_data, wr_strb);
			squr_pkg::REG_USD_LO:
				usd_base_r[31:0] <= mrg(usd_base_r[31:0], wr_data, wr_strb);
			squr_pkg::REG_USD_HI:
				usd_base_r[63:32] <= mrg(usd_base_r[63:32], wr_data, wr_strb);
			squr_pkg::REG_THR: thr_r <= wr_data[15:0];
			default: ;
			endcase
		end
	end

	assign kick_evt   = wr_en && wr_addr == squr_pkg::REG_KICK;
	assign flag_issue = state_r == S_IDLE && ctrl_r[squr_pkg::CTRL_EN]
		&& flags_dirty_r;
	// set wins over clear so a late kick or config write is never lost
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			kick_pend_r <= 1'b0;
		end else if (kick_evt) begin
			kick_pend_r <= 1'b1;
		end else if (state_r == S_RSP && phase_r == P_AIDX && mem_rsp_valid
			&& rsp_half == last_avail_r) begin
			kick_pend_r <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			flags_dirty_r <= 1'b0;
		end else if (wr_en && (wr_addr == squr_pkg::REG_CTRL
			|| wr_addr == squr_pkg::REG_THR)) begin
			flags_dirty_r <= 1'b1;
		end else if (flag_issue) begin
			flags_dirty_r <= 1'b0;
		end
	end

	assign flag_val = ctrl_r[squr_pkg::CTRL_EVIDX] ? 16'h0
		: ctrl_r[squr_pkg::CTRL_SUPP] ? squr_pkg::FLG_NO_NOTIFY
		: 16'h0;
	assign step = (ctrl_r[squr_pkg::CTRL_INORD] && cmpl_r.batch != 16'h0)
		? cmpl_r.batch : 16'h1;
	assign rsp_half = mem_req_r.addr[1] ? mem_rsp_rdata[31:16]
		: mem_rsp_rdata[15:0];
	// widened before the shift: slot offsets overflow 16 bits
	assign used_slot_addr = usd_base_r + squr_pkg::RING_OFF
		+ (64'(ring_slot(used_idx_r, qsize_r)) << squr_pkg::USED_ELEM_SH);
	assign avl_slot_addr = avl_base_r + squr_pkg::RING_OFF
		+ (64'(ring_slot(last_avail_r, qsize_r)) << squr_pkg::AVL_ENT_SH);
	assign kick_thr_addr = usd_base_r + squr_pkg::RING_OFF
		+ (64'(qsize_r) << squr_pkg::USED_ELEM_SH);

	assign mem_req       = mem_req_r;
	assign mem_req_valid = state_r == S_REQ;
	assign cmpl_ready    = state_r == S_IDLE && ctrl_r[squr_pkg::CTRL_EN]
		&& !flags_dirty_r;
	assign avail_valid   = state_r == S_OUT;
	assign avail_head    = avail_head_r;

	// completions outrank fetches so finished buffers return first
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_r   <= S_IDLE;
			phase_r   <= P_FLG;
			mem_req_r <= '0;
		end else begin
			case (state_r)
			S_IDLE: begin
				if (flag_issue) begin
					mem_req_r <= wr16(usd_base_r + squr_pkg::USED_FLG_OFF,
						flag_val);
					phase_r   <= P_FLG;
					state_r   <= S_REQ;
				end else if (cmpl_ready && cmpl_valid) begin
					mem_req_r <= wr32(used_slot_addr, cmpl_i.head);
					phase_r   <= P_EID;
					state_r   <= S_REQ;
				end else if (ctrl_r[squr_pkg::CTRL_EN] && kick_pend_r) begin
					mem_req_r <= rd16(avl_base_r + squr_pkg::AVL_IDX_OFF);
					phase_r   <= P_AIDX;
					state_r   <= S_REQ;
				end
			end
			S_REQ: begin
				if (mem_req_ready) begin
					state_r <= S_RSP;
				end
			end
			S_RSP: begin
				if (mem_rsp_valid) begin
					state_r <= S_IDLE;
					case (phase_r)
					P_FLG: begin
						if (ctrl_r[squr_pkg::CTRL_EVIDX]) begin
							mem_req_r <= wr16(kick_thr_addr, thr_r);
							phase_r   <= P_THR;
							state_r   <= S_REQ;
						end
					end
					P_AIDX: begin
						if (rsp_half != last_avail_r) begin
							mem_req_r <= rd16(avl_slot_addr);
							phase_r   <= P_AENT;
							state_r   <= S_REQ;
						end
					end
					P_AENT: state_r <= S_OUT;
					P_EID: begin
						mem_req_r <= wr32(used_slot_addr + 64'h4,
							cmpl_r.wlen);
						phase_r   <= P_ELEN;
						state_r   <= S_REQ;
					end
					P_ELEN: begin
						// index goes out only after the element is acked
						mem_req_r <= wr16(usd_base_r + squr_pkg::USED_IDX_OFF,
							used_idx_r + step);
						phase_r   <= P_UIDX;
						state_r   <= S_REQ;
					end
					default: ;
					endcase
				end
			end
			S_OUT: begin
				if (avail_ready) begin
					state_r <= S_IDLE;
				end
			end
			default: state_r <= S_IDLE;
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cmpl_r <= '0;
		end else if (cmpl_ready && cmpl_valid) begin
			cmpl_r <= cmpl_i;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			avail_head_r <= 16'h0;
		end else if (state_r == S_RSP && phase_r == P_AENT
			&& mem_rsp_valid) begin
			avail_head_r <= rsp_half;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			last_avail_r <= squr_pkg::IDX_RST;
		end else if (avail_valid && avail_ready) begin
			last_avail_r <= last_avail_r + 16'h1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			used_idx_r <= squr_pkg::IDX_RST;
			len_done_r <= 1'b0;
		end else if (state_r == S_RSP && mem_rsp_valid) begin
			if (phase_r == P_ELEN) begin
				len_done_r <= 1'b1;
			end else if (phase_r == P_UIDX) begin
				used_idx_r <= used_idx_r + step;
				len_done_r <= 1'b0;
			end
		end
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	elem_before_idx_a: assert property (
		(mem_req_valid && phase_r == P_UIDX) |-> len_done_r)
		else $error("used index written before element");
	used_step_a: assert property (
		(state_r == S_RSP && phase_r == P_UIDX && mem_rsp_valid)
		|=> used_idx_r == $past(used_idx_r) + $past(step))
		else $error("used index not advanced by batch size");
	head_word_a: assert property (
		(mem_req_valid && phase_r == P_EID)
		|-> mem_req.we && mem_req.wdata == cmpl_r.head)
		else $error("element head word wrong");
	flags_zero_a: assert property (
		(mem_req_valid && phase_r == P_FLG && ctrl_r[squr_pkg::CTRL_EVIDX])
		|-> mem_req.wdata == 32'h0)
		else $error("flags not zero under event index");
	flags_bin_a: assert property (
		(mem_req_valid && phase_r == P_FLG)
		|-> (mem_req.wdata & 32'hfffefffe) == 32'h0)
		else $error("flags outside 0 or 1");
	only_used_a: assert property (
		(mem_req_valid && mem_req.we) |-> mem_req.addr >= usd_base_r)
		else $error("write outside used ring");
	lane_le_a: assert property (
		(mem_req_valid && mem_req.we && mem_req.strb != 4'hf)
		|-> mem_req.strb == (mem_req.addr[1] ? 4'hc : 4'h3))
		else $error("half-word lanes mismatch address");
	avail_inc_a: assert property (
		(avail_valid && avail_ready)
		|=> last_avail_r == $past(last_avail_r) + 16'h1)
		else $error("consumed index not advanced");
	kick_hold_a: assert property (
		kick_evt |=> kick_pend_r)
		else $error("notification lost");
	fetch_soon_a: assert property (
		(state_r == S_RSP && phase_r == P_AIDX && mem_rsp_valid
		&& rsp_half != last_avail_r) |=> ##[0:1] mem_req_valid
		&& phase_r == P_AENT)
		else $error("entry fetch not issued");

	batch_c: cover property (state_r == S_RSP && phase_r == P_UIDX
		&& mem_rsp_valid && step > 16'h1);
	fetch_c: cover property (avail_valid && avail_ready);
	spurious_c: cover property (state_r == S_RSP && phase_r == P_AIDX
		&& mem_rsp_valid && rsp_half == last_avail_r);
endmodule

//--- verification/squr_drv_mem.sv
`timescale 1ns/1ps
module squr_drv_mem (
	input  wire logic                 aclk,
	input  wire logic                 aresetn,
	input  wire squr_pkg::squr_mreq_t mem_req,
	input  wire logic                 mem_req_valid,
	output logic                      mem_req_ready,
	output logic                      mem_rsp_valid,
	output logic [31:0]               mem_rsp_rdata
);
	logic [31:0] m [int];
	logic [1:0]  stall_r;
	int          k;
	// refuses one cycle in four, so prompt and late accepts both occur
	assign mem_req_ready = |stall_r;
	always @(posedge aclk) begin
		k = int'(mem_req.addr[31:2]);
		stall_r <= aresetn ? stall_r + 2'h1 : 2'h0;
		mem_rsp_valid <= 1'b0;
		// inverted outside a response so a stale word is never seen as data
		mem_rsp_rdata <= aresetn ? ~mem_rsp_rdata : 32'h0;
		if (aresetn && mem_req_valid && mem_req_ready) begin
			if (!m.exists(k))
				m[k] = 32'h0;
			for (int i = 0; i < 4; i++)
				if (mem_req.we && mem_req.strb[i])
					m[k][8*i+:8] = mem_req.wdata[8*i+:8];
			mem_rsp_valid <= 1'b1;
			mem_rsp_rdata <= m[k];
		end
	end
endmodule

//--- verification/squr_used_ring_tb_top.sv
`timescale 1ns/1ps
module squr_used_ring_tb_top;
	typedef struct packed {
		squr_pkg::squr_cmpl_t c;
		logic [15:0]          idx;
		logic [1:0]           slot;
	} squr_row_t;
	squr_pkg::squr_mreq_t mem_req;
	squr_pkg::squr_cmpl_t cmpl_i = '0;
	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic [7:0]  s_axil_awaddr = 8'h00;
	logic [7:0]  s_axil_araddr = 8'h00;
	logic [31:0] s_axil_wdata = 32'h0;
	logic [3:0]  s_axil_wstrb = 4'hf;
	logic        s_axil_awvalid = 1'b0;
	logic        s_axil_wvalid = 1'b0;
	logic        s_axil_bready = 1'b0;
	logic        s_axil_arvalid = 1'b0;
	logic        s_axil_rready = 1'b0;
	logic        cmpl_valid = 1'b0;
	logic        avail_ready = 1'b0;
	logic        s_axil_awready, s_axil_wready, s_axil_bvalid;
	logic        s_axil_arready, s_axil_rvalid, cmpl_ready, avail_valid;
	logic        mem_req_valid, mem_req_ready, mem_rsp_valid;
	logic [1:0]  s_axil_bresp, s_axil_rresp, rs;
	logic [31:0] s_axil_rdata, mem_rsp_rdata, rd;
	logic [15:0] avail_head;
	logic [15:0] heads [$];
	int          n_fail = 0;
	int          cmp_count = 0;
	// queue of four slots, so the last row wraps the ring
	squr_row_t   rows [4] = '{
		{32'h7, 32'h40, 16'h1, 16'h1, 2'h0},
		{32'h3, 32'h10, 16'h2, 16'h3, 2'h1},
		{32'h9, 32'h20, 16'h0, 16'h4, 2'h3},
		{32'h5, 32'h08, 16'h3, 16'h7, 2'h0}};

	always #4 aclk = ~aclk;
	always @(posedge aclk)
		if (avail_valid && avail_ready)
			heads.push_back(avail_head);

	squr_used_ring uut (.aclk, .aresetn, .s_axil_awaddr, .s_axil_awvalid,
		.s_axil_awready, .s_axil_wdata, .s_axil_wstrb, .s_axil_wvalid,
		.s_axil_wready, .s_axil_bresp, .s_axil_bvalid, .s_axil_bready,
		.s_axil_araddr, .s_axil_arvalid, .s_axil_arready, .s_axil_rdata,
		.s_axil_rresp, .s_axil_rvalid, .s_axil_rready, .mem_req,
		.mem_req_valid, .mem_req_ready, .mem_rsp_valid, .mem_rsp_rdata,
		.cmpl_i, .cmpl_valid, .cmpl_ready, .avail_head, .avail_valid,
		.avail_ready);
	squr_drv_mem drv (.aclk, .aresetn, .mem_req, .mem_req_valid,
		.mem_req_ready, .mem_rsp_valid, .mem_rsp_rdata);

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e) begin
			n_fail++;
			$display("ERROR t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic axw(input logic [7:0] a, input logic [31:0] d);
		logic aw, w;
		aw = 1'b0;
		w = 1'b0;
		@(posedge aclk);
		s_axil_awaddr <= a;
		s_axil_wdata <= d;
		s_axil_awvalid <= 1'b1;
		s_axil_wvalid <= 1'b1;
		s_axil_bready <= 1'b1;
		while (!(aw && w)) begin
			@(posedge aclk);
			if (s_axil_awready && !aw) begin
				s_axil_awvalid <= 1'b0;
				aw = 1'b1;
			end
			if (s_axil_wready && !w) begin
				s_axil_wvalid <= 1'b0;
				w = 1'b1;
			end
		end
		do @(posedge aclk); while (s_axil_bvalid !== 1'b1);
		rs = s_axil_bresp;
		s_axil_bready <= 1'b0;
	endtask
	task automatic axr(input logic [7:0] a);
		@(posedge aclk);
		s_axil_araddr <= a;
		s_axil_arvalid <= 1'b1;
		s_axil_rready <= 1'b1;
		do @(posedge aclk); while (s_axil_arready !== 1'b1);
		s_axil_arvalid <= 1'b0;
		do @(posedge aclk); while (s_axil_rvalid !== 1'b1);
		rd = s_axil_rdata;
		rs = s_axil_rresp;
		s_axil_rready <= 1'b0;
	endtask
	task automatic cmpl(input squr_pkg::squr_cmpl_t c);
		@(posedge aclk);
		cmpl_i <= c;
		cmpl_valid <= 1'b1;
		do @(posedge aclk); while (cmpl_ready !== 1'b1);
		cmpl_valid <= 1'b0;
	endtask
	function automatic logic [31:0] mw(input int a);
		return drv.m.exists(a >> 2) ? drv.m[a >> 2] : 32'h0;
	endfunction
	// sampled on the falling edge, clear of the partner's updates;
	// bounded so a wrong value fails here instead of hanging the run
	task automatic wmem(input int a, input logic [31:0] k, e);
		int n;
		n = 0;
		do begin
			@(negedge aclk);
			n++;
		end while ((mw(a) & k) !== e && n < 64);
		chk(mw(a) & k, e);
	endtask
	task automatic tdone(input string s);
		$display("test %s done", s);
	endtask
	task automatic print_verdict;
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	initial begin
		#200000;
		n_fail++;
		print_verdict();
	end

	initial begin
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		axr(squr_pkg::REG_QSIZE);
		chk(rd, {16'h0, squr_pkg::QSIZE_RST});
		axr(squr_pkg::REG_STAT);
		chk(rd, 32'h0);
		axr(8'h24);
		chk({30'h0, rs}, {30'h0, squr_pkg::RESP_SLVERR});
		axw(8'h24, 32'h1);
		chk({30'h0, rs}, {30'h0, squr_pkg::RESP_SLVERR});
		axw(squr_pkg::REG_AVL_LO, 32'h1000);
		axw(squr_pkg::REG_AVL_HI, 32'h0);
		axw(squr_pkg::REG_USD_LO, 32'h2000);
		axw(squr_pkg::REG_USD_HI, 32'h0);
		axw(squr_pkg::REG_QSIZE, 32'h4);
		axw(squr_pkg::REG_QSIZE, 32'h10000);
		axr(squr_pkg::REG_QSIZE);
		chk(rd, 32'h4);
		tdone("setup");
		drv.m[32'h800] = 32'h0;
		drv.m[32'h401] = 32'h0022_0011;
		drv.m[32'h400] = 32'h0002_0000;
		axw(squr_pkg::REG_CTRL, 32'h3);
		axw(squr_pkg::REG_KICK, 32'h1);
		do @(posedge aclk); while (avail_valid !== 1'b1);
		repeat (3) @(negedge aclk);
		chk({16'h0, avail_head}, 32'h11);
		@(posedge aclk);
		avail_ready <= 1'b1;
		do @(posedge aclk); while (heads.size() < 2);
		chk({heads[0], heads[1]}, 32'h0011_0022);
		axr(squr_pkg::REG_STAT);
		chk({16'h0, rd[15:0]}, 32'h2);
		axw(squr_pkg::REG_KICK, 32'h1);
		repeat (40) @(posedge aclk);
		chk(32'(heads.size()), 32'h2);
		tdone("fetch");
		foreach (rows[i]) begin
			cmpl(rows[i].c);
			wmem(32'h2000, 32'hffff_0000, {rows[i].idx, 16'h0});
			chk(mw(32'h2004 + 8 * rows[i].slot), rows[i].c.head);
			chk(mw(32'h2008 + 8 * rows[i].slot), rows[i].c.wlen);
			axr(squr_pkg::REG_STAT);
			chk({16'h0, rd[31:16]}, {16'h0, rows[i].idx});
		end
		tdone("rows");
		axw(squr_pkg::REG_CTRL, 32'h1);
		cmpl({32'h4, 32'h4, 16'h2});
		wmem(32'h2000, 32'hffff_0000, 32'h0008_0000);
		chk(mw(32'h201c), 32'h4);
		axw(squr_pkg::REG_CTRL, 32'hb);
		wmem(32'h2000, 32'hffff, 32'h1);
		axw(squr_pkg::REG_THR, 32'h5);
		axw(squr_pkg::REG_CTRL, 32'h7);
		wmem(32'h2000, 32'hffff, 32'h0);
		wmem(32'h2024, 32'hffff, 32'h5);
		tdone("modes");
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		axr(squr_pkg::REG_STAT);
		chk(rd, 32'h0);
		axr(squr_pkg::REG_CTRL);
		chk(rd, 32'h0);
		tdone("reset");
		print_verdict();
	end
endmodule
